// ===== rtl/ovp_device.sv
// How it works
// R01 - OV threshold is max voltage plus offset; the code uses FFh under the 5-mV table
// R02 - Paged limit: 00h A, 01h B, FFh both
// R03 - Limit: low byte code, high zero, read-only
// R04 - Limit reached only by word transactions
// R05 - 5-mV table forces limit readback to FFh
// R06 - 10-mV table: limit from max plus offset
// R07 - One response setting shared, page ignored
// R08 - Response reads as byte, fixed 80h
// R09 - OV fault latches the channel off
// R10 - OV fault sets byte, word, vout flags
// R11 - OV fault alerts host unless masked
// R12 - Enable pin, on bit or bias clears latch
// R13 - Max voltage bounds every commanded voltage
// R14 - OC fault defaults 180/60 A, shuts down
// R15 - OC warning defaults 120/40 A, warns only
// R16 - OT fault 135 C shutdown, warning 105 C
// R17 - Minimum voltage defaults to zero
// R18 - Over-max command clamps and only warns
// R19 - Fault flags stay until cleared or reset
`timescale 1ns/1ns
`default_nettype none
module ovp_device #(
  parameter logic [7:0] OV_OFFSET  = 8'h0a,
  parameter logic [7:0] VMAX_RESET = 8'hff,
  parameter logic [7:0] VCMD_RESET = 8'h00
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Management link
  ovp_link_if.dev          link,
  // Converter side, channel B in the upper byte
  input  wire logic [15:0] vout_sense,
  input  wire logic [15:0] iout_sense,
  input  wire logic [15:0] temp_sense,
  output logic      [1:0]  conv_en,
  output logic      [15:0] vout_target
);
  if (OV_OFFSET == 8'h00) begin : g_chk
    $error("ovp_device: OV_OFFSET must be non-zero");
  end

  // Pins from the host pass two flops first
  logic [1:0] en_s1_q, en_s2_q;
  logic       bias_s1_q, bias_s2_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_s1_q   <= 2'h0;
      en_s2_q   <= 2'h0;
      bias_s1_q <= 1'b0;
      bias_s2_q <= 1'b0;
    end else begin
      en_s1_q   <= link.channel_enable_pins;
      en_s2_q   <= en_s1_q;
      bias_s1_q <= link.bias_supply_pin;
      bias_s2_q <= bias_s1_q;
    end
  end

  function automatic logic is_word(input logic [7:0] c);
    return c inside {ovp_pkg::CMD_VCMD, ovp_pkg::CMD_VMAX,
      ovp_pkg::CMD_VMIN, ovp_pkg::CMD_OV_LIM, ovp_pkg::CMD_OC_FLT,
      ovp_pkg::CMD_OC_WRN, ovp_pkg::CMD_OT_FLT, ovp_pkg::CMD_OT_WRN,
      ovp_pkg::CMD_ST_WORD};
  endfunction : is_word

  function automatic logic is_known(input logic [7:0] c);
    return is_word(c) || (c inside {ovp_pkg::CMD_PAGE,
      ovp_pkg::CMD_OPER, ovp_pkg::CMD_ONOFF, ovp_pkg::CMD_CLEAR,
      ovp_pkg::CMD_AL_MASK, ovp_pkg::CMD_OV_RESP, ovp_pkg::CMD_ST_BYTE,
      ovp_pkg::CMD_ST_VOUT, ovp_pkg::CMD_ST_IOUT, ovp_pkg::CMD_ST_TEMP,
      ovp_pkg::CMD_DAC_SEL});
  endfunction : is_known

  // Transaction decode
  logic       ack_q, err_q;
  logic [15:0] rdata_q, rd_mux;
  logic       take, ok, wr, clr_all;
  logic [7:0] page_q, onoff_q, mask_q, dac_q;
  logic [1:0] sel;
  logic       rch;

  assign take = link.req & ~ack_q;
  // Wrong size or unknown code is refused with an error
  assign ok   = is_known(link.cmd) && (link.word == is_word(link.cmd)) //R04
                && !(!link.rd && link.cmd == ovp_pkg::CMD_OV_RESP);
  assign wr   = take & ok & ~link.rd;
  assign clr_all = wr && link.cmd == ovp_pkg::CMD_CLEAR;
  assign sel[0] = page_q == ovp_pkg::PAGE_A || page_q == ovp_pkg::PAGE_ALL;
  assign sel[1] = page_q == ovp_pkg::PAGE_B || page_q == ovp_pkg::PAGE_ALL;
  // Reads on the both-channels page answer from channel A
  assign rch = page_q == ovp_pkg::PAGE_B; //R02

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      page_q  <= ovp_pkg::PAGE_A;
      onoff_q <= ovp_pkg::ONOFF_RST;
      mask_q  <= ovp_pkg::MASK_RST;
      dac_q   <= ovp_pkg::DAC_RST;
    end else if (wr) begin
      unique case (link.cmd)
        ovp_pkg::CMD_PAGE:    page_q  <= link.wdata[7:0];
        ovp_pkg::CMD_ONOFF:   onoff_q <= link.wdata[7:0];
        ovp_pkg::CMD_AL_MASK: mask_q  <= link.wdata[7:0];
        ovp_pkg::CMD_DAC_SEL: dac_q   <= link.wdata[7:0];
        default: ;
      endcase
    end
  end

  // Per-channel state
  logic [7:0] vmax_q [2];
  logic [7:0] vcmd_q [2];
  logic [7:0] vmin_q [2];
  logic [7:0] oper_q [2];
  logic [7:0] ocf_q  [2];
  logic [7:0] ocw_q  [2];
  logic [7:0] otf_q  [2];
  logic [7:0] otw_q  [2];
  logic [7:0] sv_q   [2];
  logic [7:0] si_q   [2];
  logic [7:0] st_q   [2];
  logic [7:0] ovlim  [2];
  logic [7:0] sbyte  [2];
  logic [1:0] latch_q, alert_src;

  for (genvar ch = 0; ch < 2; ch++) begin : g_ch
    logic [8:0] sum;
    logic [7:0] vs, is, ts, sv_set, si_set, st_set, sv_clr, si_clr, st_clr;
    logic       ov_evt, oc_f, oc_w, ot_f, ot_w, want_on, cw;
    assign vs = vout_sense[ch*8 +: 8];
    assign is = iout_sense[ch*8 +: 8];
    assign ts = temp_sense[ch*8 +: 8];
    assign sum = {1'b0, vmax_q[ch]} + {1'b0, OV_OFFSET}; //R01
    always_comb begin
      if (dac_q[ovp_pkg::DAC_5MV]) ovlim[ch] = ovp_pkg::OV_LIM_5MV; //R05
      else if (sum[8]) ovlim[ch] = 8'hff;
      else ovlim[ch] = sum[7:0]; //R06
    end
    assign ov_evt = vs > ovlim[ch];
    assign oc_f = is >= ocf_q[ch]; //R14
    assign oc_w = is >= ocw_q[ch]; //R15
    assign ot_f = ts >= otf_q[ch]; //R16
    assign ot_w = ts >= otw_q[ch];
    assign cw = wr & sel[ch];
    assign sv_set = ({7'h0, ov_evt} << ovp_pkg::SV_OV_FLT)
                  | ({7'h0, vcmd_q[ch] > vmax_q[ch]}
                     << ovp_pkg::SV_MAX_WRN); //R18
    assign si_set = ({7'h0, oc_f} << ovp_pkg::SI_OC_FLT)
                  | ({7'h0, oc_w} << ovp_pkg::SI_OC_WRN);
    assign st_set = ({7'h0, ot_f} << ovp_pkg::ST_OT_FLT)
                  | ({7'h0, ot_w} << ovp_pkg::ST_OT_WRN);
    assign sv_clr = {8{clr_all}} | ({8{cw && link.cmd ==
                    ovp_pkg::CMD_ST_VOUT}} & link.wdata[7:0]);
    assign si_clr = {8{clr_all}} | ({8{cw && link.cmd ==
                    ovp_pkg::CMD_ST_IOUT}} & link.wdata[7:0]);
    assign st_clr = {8{clr_all}} | ({8{cw && link.cmd ==
                    ovp_pkg::CMD_ST_TEMP}} & link.wdata[7:0]);
    // Off request comes from pin and/or on bit as configured
    assign want_on = bias_s2_q
      & (~onoff_q[ovp_pkg::ONOFF_PIN] | en_s2_q[ch])
      & (~onoff_q[ovp_pkg::ONOFF_CMD] | oper_q[ch][ovp_pkg::OPER_ON]);

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        vmax_q[ch] <= VMAX_RESET;
        vcmd_q[ch] <= VCMD_RESET;
        vmin_q[ch] <= ovp_pkg::VMIN_RST; //R17
        oper_q[ch] <= ovp_pkg::OPER_RST;
        ocf_q[ch]  <= ch == 0 ? ovp_pkg::OC_FLT_A_RST : ovp_pkg::OC_FLT_B_RST;
        ocw_q[ch]  <= ch == 0 ? ovp_pkg::OC_WRN_A_RST : ovp_pkg::OC_WRN_B_RST;
        otf_q[ch]  <= ovp_pkg::OT_FLT_RST;
        otw_q[ch]  <= ovp_pkg::OT_WRN_RST;
      end else if (cw) begin //R02
        unique case (link.cmd)
          ovp_pkg::CMD_VMAX:   vmax_q[ch] <= link.wdata[7:0];
          ovp_pkg::CMD_VCMD:   vcmd_q[ch] <= link.wdata[7:0];
          ovp_pkg::CMD_VMIN:   vmin_q[ch] <= link.wdata[7:0];
          ovp_pkg::CMD_OPER:   oper_q[ch] <= link.wdata[7:0];
          ovp_pkg::CMD_OC_FLT: ocf_q[ch]  <= link.wdata[7:0];
          ovp_pkg::CMD_OC_WRN: ocw_q[ch]  <= link.wdata[7:0];
          ovp_pkg::CMD_OT_FLT: otf_q[ch]  <= link.wdata[7:0];
          ovp_pkg::CMD_OT_WRN: otw_q[ch]  <= link.wdata[7:0];
          default: ; //R03
        endcase
      end
    end

    // Set wins over clear so no event is lost
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sv_q[ch] <= 8'h00;
        si_q[ch] <= 8'h00;
        st_q[ch] <= 8'h00;
      end else begin
        sv_q[ch] <= (sv_q[ch] & ~sv_clr) | sv_set; //R19
        si_q[ch] <= (si_q[ch] & ~si_clr) | si_set;
        st_q[ch] <= (st_q[ch] & ~st_clr) | st_set;
      end
    end

    // Fault latch; only an off request or bias loss releases it
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) latch_q[ch] <= 1'b0;
      else if (ov_evt | oc_f | ot_f) latch_q[ch] <= 1'b1; //R09
      else if (!want_on) latch_q[ch] <= 1'b0; //R12
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        conv_en[ch] <= 1'b0;
        vout_target[ch*8 +: 8] <= 8'h00;
      end else begin
        conv_en[ch] <= want_on & ~latch_q[ch] & ~(ov_evt | oc_f | ot_f);
        if (vcmd_q[ch] > vmax_q[ch])
          vout_target[ch*8 +: 8] <= vmax_q[ch]; //R13
        else if (vcmd_q[ch] < vmin_q[ch])
          vout_target[ch*8 +: 8] <= vmin_q[ch];
        else
          vout_target[ch*8 +: 8] <= vcmd_q[ch];
      end
    end

    always_comb begin
      sbyte[ch] = 8'h00;
      sbyte[ch][ovp_pkg::SB_VOUT_OV] = sv_q[ch][ovp_pkg::SV_OV_FLT]; //R10
      sbyte[ch][ovp_pkg::SB_IOUT_OC] = si_q[ch][ovp_pkg::SI_OC_FLT];
      sbyte[ch][ovp_pkg::SB_TEMP]    = |st_q[ch];
      sbyte[ch][ovp_pkg::SB_OTHER]   = sv_q[ch][ovp_pkg::SV_MAX_WRN]
                                     | si_q[ch][ovp_pkg::SI_OC_WRN];
    end
    assign alert_src[ch] = |(sv_q[ch] & ~mask_q) | (|si_q[ch])
                         | (|st_q[ch]);
  end

  always_comb begin
    rd_mux = 16'h0000;
    unique case (link.cmd)
      ovp_pkg::CMD_PAGE:    rd_mux[7:0] = page_q;
      ovp_pkg::CMD_OPER:    rd_mux[7:0] = oper_q[rch];
      ovp_pkg::CMD_ONOFF:   rd_mux[7:0] = onoff_q;
      ovp_pkg::CMD_AL_MASK: rd_mux[7:0] = mask_q;
      ovp_pkg::CMD_DAC_SEL: rd_mux[7:0] = dac_q;
      ovp_pkg::CMD_VCMD:    rd_mux[7:0] = vcmd_q[rch];
      ovp_pkg::CMD_VMAX:    rd_mux[7:0] = vmax_q[rch];
      ovp_pkg::CMD_VMIN:    rd_mux[7:0] = vmin_q[rch];
      ovp_pkg::CMD_OV_LIM:  rd_mux[7:0] = ovlim[rch]; //R03
      ovp_pkg::CMD_OV_RESP: rd_mux[7:0] = ovp_pkg::OV_ACTION; //R07 R08
      ovp_pkg::CMD_OC_FLT:  rd_mux[7:0] = ocf_q[rch];
      ovp_pkg::CMD_OC_WRN:  rd_mux[7:0] = ocw_q[rch];
      ovp_pkg::CMD_OT_FLT:  rd_mux[7:0] = otf_q[rch];
      ovp_pkg::CMD_OT_WRN:  rd_mux[7:0] = otw_q[rch];
      ovp_pkg::CMD_ST_BYTE: rd_mux[7:0] = sbyte[rch];
      ovp_pkg::CMD_ST_WORD: begin
        rd_mux[7:0] = sbyte[rch];
        rd_mux[ovp_pkg::SW_VOUT] = |sv_q[rch]; //R10
        rd_mux[ovp_pkg::SW_IOUT] = |si_q[rch];
      end
      ovp_pkg::CMD_ST_VOUT: rd_mux[7:0] = sv_q[rch];
      ovp_pkg::CMD_ST_IOUT: rd_mux[7:0] = si_q[rch];
      ovp_pkg::CMD_ST_TEMP: rd_mux[7:0] = st_q[rch];
      default: ;
    endcase
  end

  // Answer one cycle after the request is seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_q   <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= 16'h0000;
    end else begin
      ack_q <= take;
      if (take) begin
        err_q   <= ~ok;
        rdata_q <= (ok && link.rd) ? rd_mux : 16'h0000;
      end
    end
  end

  logic alert_n_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) alert_n_q <= 1'b1;
    else alert_n_q <= ~|alert_src; //R11
  end

  assign link.ack   = ack_q;
  assign link.err   = err_q;
  assign link.rdata = rdata_q;
  assign link.host_alert_output_n = alert_n_q;
endmodule : ovp_device
`default_nettype wire

// ===== rtl/ovp_host.sv
`timescale 1ns/1ns
`default_nettype none
module ovp_host (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Interrupt
  output logic             irq,
  // Management link
  ovp_link_if.host         link
);
  logic        req_q, rd_q, word_q, busy_q, err_q;
  logic [7:0]  cmd_q;
  logic [15:0] wdata_q, res_q;
  logic [2:0]  pins_q, ist_q, imask_q, iset, iclr;
  logic        al_s1_q, al_s2_q, al_s3_q;
  logic        acc, wr;
  logic [31:0] rmux;

  // One wait state so read data leaves a flop
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & penable & ~pready;
      if (psel & penable & ~pready & ~pwrite) prdata <= rmux;
    end
  end

  always_comb begin
    rmux = 32'h0000_0000;
    unique case (paddr)
      ovp_pkg::REG_CMD:      rmux = {22'h0, word_q, rd_q, cmd_q};
      ovp_pkg::REG_WDATA:    rmux = {16'h0, wdata_q};
      ovp_pkg::REG_RESULT: begin
        rmux[15:0] = res_q;
        rmux[ovp_pkg::RES_BUSY_BIT] = busy_q;
        rmux[ovp_pkg::RES_ERR_BIT]  = err_q;
      end
      ovp_pkg::REG_IRQ_STAT: rmux = {29'h0, ist_q};
      ovp_pkg::REG_IRQ_MASK: rmux = {29'h0, imask_q};
      ovp_pkg::REG_PINS:     rmux = {29'h0, pins_q};
      default: ;
    endcase
  end

  // Order register and pins; a new order while busy is dropped
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_q   <= 8'h00;
      rd_q    <= 1'b0;
      word_q  <= 1'b0;
      wdata_q <= 16'h0000;
      pins_q  <= ovp_pkg::PINS_RST;
      imask_q <= 3'h0;
    end else if (wr) begin
      unique case (paddr)
        ovp_pkg::REG_CMD: if (!busy_q) begin
          cmd_q  <= pwdata[7:0];
          rd_q   <= pwdata[ovp_pkg::CMD_RD_BIT];
          word_q <= pwdata[ovp_pkg::CMD_WORD_BIT];
        end
        ovp_pkg::REG_WDATA:    wdata_q <= pwdata[15:0];
        ovp_pkg::REG_IRQ_MASK: imask_q <= pwdata[2:0];
        ovp_pkg::REG_PINS:     pins_q  <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  // Request held until the device acknowledges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_q  <= 1'b0;
      busy_q <= 1'b0;
      err_q  <= 1'b0;
      res_q  <= 16'h0000;
    end else if (busy_q) begin
      if (link.ack) begin
        req_q  <= 1'b0;
        busy_q <= 1'b0;
        err_q  <= link.err;
        res_q  <= link.rdata;
      end
    end else if (wr && paddr == ovp_pkg::REG_CMD
                 && pwdata[ovp_pkg::CMD_GO_BIT]) begin
      req_q  <= 1'b1;
      busy_q <= 1'b1;
    end
  end

  // Alert is an async pin here; edge taken after the second flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_s1_q <= 1'b1;
      al_s2_q <= 1'b1;
      al_s3_q <= 1'b1;
    end else begin
      al_s1_q <= link.host_alert_output_n;
      al_s2_q <= al_s1_q;
      al_s3_q <= al_s2_q;
    end
  end

  always_comb begin
    iset = 3'h0;
    iset[ovp_pkg::IRQ_DONE]  = busy_q & link.ack;
    iset[ovp_pkg::IRQ_ERR]   = busy_q & link.ack & link.err;
    iset[ovp_pkg::IRQ_ALERT] = al_s3_q & ~al_s2_q;
  end
  assign iclr = (wr && paddr == ovp_pkg::REG_IRQ_STAT) ? pwdata[2:0] : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ist_q <= 3'h0;
      irq   <= 1'b0;
    end else begin
      ist_q <= (ist_q & ~iclr) | iset;
      irq   <= |(ist_q & imask_q);
    end
  end

  assign link.req   = req_q;
  assign link.cmd   = cmd_q;
  assign link.rd    = rd_q;
  assign link.word  = word_q;
  assign link.wdata = wdata_q;
  assign link.channel_enable_pins = pins_q[1:0];
  assign link.bias_supply_pin     = pins_q[ovp_pkg::PIN_BIAS];
endmodule : ovp_host
`default_nettype wire

// ===== rtl/ovp_link_if.sv
`timescale 1ns/1ns
`default_nettype none
interface ovp_link_if;
  logic        req;
  logic [7:0]  cmd;
  logic        rd;
  logic        word;
  logic [15:0] wdata;
  logic        ack;
  logic        err;
  logic [15:0] rdata;
  logic [1:0]  channel_enable_pins;
  logic        bias_supply_pin;
  logic        host_alert_output_n;
  modport dev  (input req, cmd, rd, word, wdata, channel_enable_pins,
                bias_supply_pin, output ack, err, rdata,
                host_alert_output_n);
  modport host (output req, cmd, rd, word, wdata, channel_enable_pins,
                bias_supply_pin, input ack, err, rdata,
                host_alert_output_n);
endinterface : ovp_link_if
`default_nettype wire

// ===== rtl/ovp_pkg.sv
package ovp_pkg;
  // Command codes seen on the management link
  localparam logic [7:0] CMD_PAGE     = 8'h00;
  localparam logic [7:0] CMD_OPER     = 8'h01;
  localparam logic [7:0] CMD_ONOFF    = 8'h02;
  localparam logic [7:0] CMD_CLEAR    = 8'h03;
  localparam logic [7:0] CMD_AL_MASK  = 8'h1b;
  localparam logic [7:0] CMD_VCMD     = 8'h21;
  localparam logic [7:0] CMD_VMAX     = 8'h24;
  localparam logic [7:0] CMD_VMIN     = 8'h2b;
  localparam logic [7:0] CMD_OV_LIM   = 8'h40;
  localparam logic [7:0] CMD_OV_RESP  = 8'h41;
  localparam logic [7:0] CMD_OC_FLT   = 8'h46;
  localparam logic [7:0] CMD_OC_WRN   = 8'h4a;
  localparam logic [7:0] CMD_OT_FLT   = 8'h4f;
  localparam logic [7:0] CMD_OT_WRN   = 8'h51;
  localparam logic [7:0] CMD_ST_BYTE  = 8'h78;
  localparam logic [7:0] CMD_ST_WORD  = 8'h79;
  localparam logic [7:0] CMD_ST_VOUT  = 8'h7a;
  localparam logic [7:0] CMD_ST_IOUT  = 8'h7b;
  localparam logic [7:0] CMD_ST_TEMP  = 8'h7d;
  localparam logic [7:0] CMD_DAC_SEL  = 8'hdd;
  // Page values
  localparam logic [7:0] PAGE_A       = 8'h00;
  localparam logic [7:0] PAGE_B       = 8'h01;
  localparam logic [7:0] PAGE_ALL     = 8'hff;
  // Fixed answers and reset values
  localparam logic [7:0] OV_ACTION    = 8'h80;
  localparam logic [7:0] OV_LIM_5MV   = 8'hff;
  localparam logic [7:0] VMIN_RST     = 8'h00;
  localparam logic [7:0] OC_FLT_A_RST = 8'hb4;
  localparam logic [7:0] OC_FLT_B_RST = 8'h3c;
  localparam logic [7:0] OC_WRN_A_RST = 8'h78;
  localparam logic [7:0] OC_WRN_B_RST = 8'h28;
  localparam logic [7:0] OT_FLT_RST   = 8'h87;
  localparam logic [7:0] OT_WRN_RST   = 8'h69;
  localparam logic [7:0] ONOFF_RST    = 8'h0c;
  localparam logic [7:0] OPER_RST     = 8'h80;
  localparam logic [7:0] MASK_RST     = 8'h00;
  localparam logic [7:0] DAC_RST      = 8'h00;
  // Field positions
  localparam int ONOFF_PIN  = 3;
  localparam int ONOFF_CMD  = 2;
  localparam int OPER_ON    = 7;
  localparam int DAC_5MV    = 0;
  localparam int SV_OV_FLT  = 7;
  localparam int SV_MAX_WRN = 3;
  localparam int SI_OC_FLT  = 7;
  localparam int SI_OC_WRN  = 5;
  localparam int ST_OT_FLT  = 7;
  localparam int ST_OT_WRN  = 6;
  localparam int SB_VOUT_OV = 5;
  localparam int SB_IOUT_OC = 4;
  localparam int SB_TEMP    = 2;
  localparam int SB_OTHER   = 0;
  localparam int SW_VOUT    = 15;
  localparam int SW_IOUT    = 14;
  // Host register map (APB byte offsets)
  localparam logic [7:0] REG_CMD      = 8'h00;
  localparam logic [7:0] REG_WDATA    = 8'h04;
  localparam logic [7:0] REG_RESULT   = 8'h08;
  localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
  localparam logic [7:0] REG_IRQ_MASK = 8'h10;
  localparam logic [7:0] REG_PINS     = 8'h14;
  localparam int CMD_RD_BIT   = 8;
  localparam int CMD_WORD_BIT = 9;
  localparam int CMD_GO_BIT   = 31;
  localparam int RES_BUSY_BIT = 16;
  localparam int RES_ERR_BIT  = 17;
  localparam int IRQ_DONE     = 0;
  localparam int IRQ_ERR      = 1;
  localparam int IRQ_ALERT    = 2;
  localparam int PIN_BIAS     = 2;
  localparam logic [2:0] PINS_RST = 3'h7;
endpackage : ovp_pkg

// ===== sim/ovp_link_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module ovp_link_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // Link
  input wire logic        req,
  input wire logic [7:0]  cmd,
  input wire logic        rd,
  input wire logic        word,
  input wire logic        ack,
  input wire logic        err,
  input wire logic [15:0] rdata
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_take;
    req && !ack;
  endsequence
  // Answer to one command with its read flag and size
  sequence s_ans(logic [7:0] c, logic r, logic w);
    ack && cmd == c && rd == r && word == w;
  endsequence
  a_take_ack: assert property (s_take |=> ack)
    else $error("request not answered");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("answer too long");
  a_req_held: assert property (s_take |=>
    $stable(cmd) && $stable(rd) && $stable(word)) else $error("request moved");
  a_resp_value: assert property (s_ans(8'h41, 1, 0) |->
    rdata == 16'h0080 && !err) else $error("response value wrong");
  a_resp_fixed: assert property (s_ans(8'h41, 0, 0) |-> err)
    else $error("response write taken");
  a_lim_upper: assert property (s_ans(8'h40, 1, 1) |->
    rdata[15:8] == 8'h00 && !err) else $error("limit upper byte set");
  a_lim_size: assert property (s_ans(8'h40, 1, 0) |-> err)
    else $error("byte limit read taken");
  a_lim_write: assert property (s_ans(8'h40, 0, 1) |->
    !err && rdata == 16'h0000) else $error("limit write answer wrong");
endmodule : ovp_link_asserts
`default_nettype wire

// ===== sim/ovp_tb.sv
`timescale 1ns/1ns
`default_nettype none
module ovp_tb;
  localparam logic [7:0] OFS = 8'h0a;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        irq;
  logic [15:0] vs = 16'h0;
  logic [15:0] ia = 16'h0;
  logic [15:0] ta = 16'h0;
  logic        pslverr;
  logic [1:0]  conv_en;
  logic [15:0] vtgt;
  logic [31:0] q;
  int          failures = 0;
  int          comparisons = 0;
  logic [7:0]  dc [5] = '{8'h46, 8'h4a, 8'h4f, 8'h51, 8'h2b};
  logic [7:0]  ex [2][5] = '{'{8'hb4, 8'h78, 8'h87, 8'h69, 8'h00},
                             '{8'h3c, 8'h28, 8'h87, 8'h69, 8'h00}};
  ovp_link_if lk ();
  ovp_host i_ovp_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .link(lk));
  ovp_device #(.OV_OFFSET(OFS)) i_ovp_device (.pclk(pclk),
    .presetn(presetn), .link(lk), .vout_sense(vs), .iout_sense(ia),
    .temp_sense(ta), .conv_en(conv_en), .vout_target(vtgt));
  ovp_link_asserts i_ovp_link_asserts (.pclk(pclk), .presetn(presetn),
    .req(lk.req), .cmd(lk.cmd), .rd(lk.rd), .word(lk.word), .ack(lk.ack),
    .err(lk.err), .rdata(lk.rdata));
  always #25 pclk = ~pclk;
  task automatic test_done;
    if (failures == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  task automatic chk(input string n, input logic [31:0] s, e);
    comparisons++;
    if (s !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, s);
    end
  endtask : chk
  // A wait that runs out ends the run as a failure
  task automatic timeout(input int n);
    if (n >= 40) begin
      chk("timeout", 32'h1, 32'h0);
      test_done();
    end
  endtask : timeout
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    timeout(n);
    q = prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // c is {word, read, command code}
  task automatic cc(input string s, input logic [9:0] c,
                    input logic [15:0] d, input logic [17:0] e);
    int n;
    n = 0;
    apb(1'b1, 8'h04, {16'h0, d});
    apb(1'b1, 8'h00, {1'b1, 21'h0, c});
    do begin
      apb(1'b0, 8'h08, 32'h0);
      n++;
    end while (q[16] !== 1'b0 && n < 40);
    timeout(n);
    chk(s, {14'h0, q[17:0]}, {14'h0, e});
  endtask : cc
  task automatic wce(input logic [1:0] e);
    int n;
    n = 0;
    while (conv_en !== e && n < 40) begin
      @(posedge pclk);
      n++;
    end
    chk("conv_en", {30'h0, conv_en}, {30'h0, e});
    if (conv_en !== e) test_done();
  endtask : wce
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h14, 32'h0);
    chk("pins", q, 32'h7);
    apb(1'b0, 8'h18, 32'h0);
    chk("unmapped", q, 32'h0);
    wce(2'b11);
    for (int p = 0; p < 2; p++) begin
      cc("page", 10'h000, 16'(p), 18'h0);
      for (int i = 0; i < 5; i++)
        cc("dflt", {2'b11, dc[i]}, 16'h0, {10'h0, ex[p][i]});
      cc("resp", 10'h141, 16'h0, 18'h00080);
      cc("limit", 10'h340, 16'h0, 18'h000ff);
    end
    cc("resp_wr", 10'h041, 16'h0, 18'h20000);
    cc("page", 10'h000, 16'h00ff, 18'h0);
    cc("vmax", 10'h224, 16'h0040, 18'h0);
    cc("page", 10'h000, 16'h0001, 18'h0);
    cc("lim_b", 10'h340, 16'h0, {10'h0, 8'h40 + OFS});
    cc("page", 10'h000, 16'h0000, 18'h0);
    cc("lim_wr", 10'h240, 16'h1234, 18'h0);
    cc("lim_a", 10'h340, 16'h0, {10'h0, 8'h40 + OFS});
    cc("lim_byte", 10'h140, 16'h0, 18'h20000);
    cc("dac", 10'h0dd, 16'h0001, 18'h0);
    cc("lim_5mv", 10'h340, 16'h0, 18'h000ff);
    cc("dac", 10'h0dd, 16'h0000, 18'h0);
    apb(1'b1, 8'h10, 32'h4);
    apb(1'b1, 8'h0c, 32'h7);
    vs <= {8'h00, 8'h41 + OFS};
    wce(2'b10);
    vs <= 16'h0000;
    cc("st_byte", 10'h178, 16'h0, 18'h00020);
    cc("st_word", 10'h379, 16'h0, 18'h08020);
    cc("st_vout", 10'h17a, 16'h0, 18'h00080);
    chk("alert_n", {31'h0, lk.host_alert_output_n}, 32'h0);
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, 8'h0c, 32'h0);
    chk("irq_stat", q, 32'h5);
    wce(2'b10);
    apb(1'b1, 8'h14, 32'h6);
    apb(1'b0, 8'h14, 32'h0);
    apb(1'b1, 8'h14, 32'h7);
    wce(2'b11);
    cc("clear", 10'h003, 16'h0, 18'h0);
    cc("st_clr", 10'h17a, 16'h0, 18'h0);
    apb(1'b1, 8'h0c, 32'h7);
    apb(1'b0, 8'h0c, 32'h0);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    cc("mask", 10'h01b, 16'h0080, 18'h0);
    vs <= {8'h00, 8'h41 + OFS};
    wce(2'b10);
    vs <= 16'h0000;
    cc("st_vout", 10'h17a, 16'h0, 18'h00080);
    chk("alert_n", {31'h0, lk.host_alert_output_n}, 32'h1);
    apb(1'b1, 8'h14, 32'h3);
    apb(1'b0, 8'h14, 32'h0);
    apb(1'b1, 8'h14, 32'h7);
    wce(2'b11);
    cc("vcmd", 10'h221, 16'h0050, 18'h0);
    chk("target", {16'h0, vtgt}, 32'h0040);
    chk("conv_on", {30'h0, conv_en}, 32'h3);
    cc("st_max", 10'h17a, 16'h0, 18'h00088);
    ia <= 16'h0078;
    cc("st_iout", 10'h17b, 16'h0, 18'h00020);
    chk("oc_warn_on", {30'h0, conv_en}, 32'h3);
    ia <= 16'h3c78;
    wce(2'b01);
    ta <= 16'h0087;
    wce(2'b00);
    cc("st_temp", 10'h17d, 16'h0, 18'h000c0);
    chk("pslverr", {31'h0, pslverr}, 32'h0);
    test_done();
  end
endmodule : ovp_tb
`default_nettype wire
